// ===== include/fpm_pkg.sv
// constants and carrier types shared by the floating-point multiplier files
`default_nettype none

package fpm_pkg;

	// ************************************************************
	// operand and result widths
	// ************************************************************
	localparam int FPM_FRAC_BITS = 8;                      // input fraction width
	localparam int FPM_EXP_BITS  = 7;                      // exponent field width
	localparam int FPM_PROD_BITS = 2 * FPM_FRAC_BITS;      // product fraction width
	localparam int FPM_EXT_BITS  = FPM_EXP_BITS + 1;       // exponent path with guard bit
	localparam int FPM_SHF_BITS  = $clog2(FPM_PROD_BITS + 1); // shift count, zero product too

	// ************************************************************
	// exponent encoding
	// ************************************************************
	localparam logic [FPM_EXT_BITS-1:0] FPM_EXP_BIAS = 8'h40;  // excess 2^(exp_bits-1)
	localparam logic [FPM_EXP_BITS-1:0] FPM_EXP_TOP  = 7'h7F;  // largest exponent code
	localparam logic [FPM_EXP_BITS-1:0] FPM_EXP_ZERO = 7'h00;  // exponent of the zero value
	localparam int FPM_EXT_MSB = FPM_EXT_BITS - 1;             // guard bit position

	// ************************************************************
	// special fraction codes
	// ************************************************************
	localparam logic [FPM_FRAC_BITS-1:0] FPM_FRAC_ZERO = 8'h00;     // zero input fraction
	localparam logic [FPM_PROD_BITS-1:0] FPM_PROD_ZERO = 16'h0000;  // zero product fraction
	localparam logic [FPM_PROD_BITS-1:0] FPM_PROD_NAN  = 16'h8000;  // 2^(width-1) marks NaN
	localparam logic [FPM_EXP_BITS-1:0]  FPM_NAN_EXP   = 7'h40;     // any nonzero code serves

	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		logic                     sign;  // 1 positive, 0 negative
		logic [FPM_FRAC_BITS-1:0] frac;  // 0.frac, implied zero left of the point
		logic [FPM_EXP_BITS-1:0]  exp;   // excess coded exponent
	} fpm_operand_t;

	typedef struct packed {
		logic                     sign;
		logic [FPM_PROD_BITS-1:0] frac;
		logic [FPM_EXP_BITS-1:0]  exp;
	} fpm_result_t;

	typedef struct packed {
		logic overflow;
		logic underflow;
		logic infinity;
		logic nan;
	} fpm_flags_t;

endpackage

`default_nettype wire

// ===== logic/fpm_normalizer.sv
// leading-zero count and left shift of the double-width product fraction
`default_nettype none
`timescale 1ns/10ps

module fpm_normalizer
	import fpm_pkg::*;
(
	// unnormalized product
	input  wire logic [FPM_PROD_BITS-1:0] i_frac,
	// normalized product and shift applied
	output logic      [FPM_PROD_BITS-1:0] o_frac,
	output logic      [FPM_SHF_BITS-1:0]  o_shift
);

	// ************************************************************
	// zero run from the top down to each bit
	// ************************************************************
	logic [FPM_PROD_BITS-1:0] zero_from;  // bit i: bits top..i all zero

	genvar gi;
	generate
		for (gi = FPM_PROD_BITS - 1; gi >= 0; gi--) begin : g_run
			if (gi == FPM_PROD_BITS - 1) begin : g_top
				assign zero_from[gi] = ~i_frac[gi];
			end else begin : g_low
				assign zero_from[gi] = zero_from[gi+1] & ~i_frac[gi];
			end
		end
	endgenerate

	// count of leading zeros; a zero product stops at the full width
	always_comb begin
		o_shift = '0;
		for (int k = 0; k < FPM_PROD_BITS; k++) begin
			o_shift = o_shift + FPM_SHF_BITS'(zero_from[k]);
		end
	end

	// shift until the top bit is one
	assign o_frac = i_frac << o_shift;

endmodule

`default_nettype wire

// ===== logic/fpm_float_multiplier.sv
// combinational sign, fraction and exponent floating-point multiplier
`default_nettype none
`timescale 1ns/10ps

module fpm_float_multiplier
	import fpm_pkg::*;
#(
	parameter bit CHECK_EN = 1'b0  // adds range, boundary and NaN handling
)(
	// sampling clock for the checks only, the datapath never reads it
	input  wire logic                     i_clk_sys,
	// operand a
	input  wire logic                     i_sign_in_a,
	input  wire logic [FPM_FRAC_BITS-1:0] i_frac_in_a,
	input  wire logic [FPM_EXP_BITS-1:0]  i_exp_in_a,
	// operand b
	input  wire logic                     i_sign_in_b,
	input  wire logic [FPM_FRAC_BITS-1:0] i_frac_in_b,
	input  wire logic [FPM_EXP_BITS-1:0]  i_exp_in_b,
	// result
	output logic                          o_sign_out,
	output logic      [FPM_PROD_BITS-1:0] o_frac_out,
	output logic      [FPM_EXP_BITS-1:0]  o_exp_out,
	// range and boundary flags, zero unless CHECK_EN
	output logic                          o_overflow,
	output logic                          o_underflow,
	output logic                          o_infinity,
	output logic                          o_nan
);

	// ************************************************************
	// operand gathering
	// ************************************************************
	fpm_operand_t op_a;
	fpm_operand_t op_b;
	fpm_result_t  raw;     // result before any boundary substitution
	fpm_result_t  res;     // result driven out
	fpm_flags_t   flags;

	// sign, fraction and exponent kept as separate fields
	assign op_a = '{sign: i_sign_in_a, frac: i_frac_in_a, exp: i_exp_in_a};
	assign op_b = '{sign: i_sign_in_b, frac: i_frac_in_b, exp: i_exp_in_b};

	// ************************************************************
	// sign
	// ************************************************************
	logic sign_prod;

	// one means positive, so equal signs give a positive product
	assign sign_prod = ~(op_a.sign ^ op_b.sign);

	// ************************************************************
	// fraction product
	// ************************************************************
	logic [FPM_PROD_BITS-1:0] frac_prod;   // unnormalized, over 2^(2*frac_bits)
	logic [FPM_PROD_BITS-1:0] frac_norm;
	logic [FPM_SHF_BITS-1:0]  norm_shift;

	// each fraction is numerator over 2^frac_bits, product over its square
	assign frac_prod = FPM_PROD_BITS'(op_a.frac) * FPM_PROD_BITS'(op_b.frac);

	fpm_normalizer u_norm (
		.i_frac  (frac_prod),
		.o_frac  (frac_norm),
		.o_shift (norm_shift)
	);

	// ************************************************************
	// exponent path with one guard bit
	// ************************************************************
	logic [FPM_EXT_BITS-1:0] exp_sum;   // sum of the two codes
	logic [FPM_EXT_BITS-1:0] exp_unb;   // after removing one bias
	logic [FPM_EXT_BITS-1:0] exp_fin;   // after the normalization correction

	// both codes carry a bias, so one bias comes back out
	always_comb begin
		exp_sum = FPM_EXT_BITS'(op_a.exp) + FPM_EXT_BITS'(op_b.exp);
		exp_unb = exp_sum - FPM_EXP_BIAS;
		exp_fin = exp_unb - FPM_EXT_BITS'(norm_shift);
	end

	// the field itself is the low bits; the guard bit only feeds detection
	assign raw = '{sign: sign_prod, frac: frac_norm, exp: exp_fin[FPM_EXP_BITS-1:0]};

	// ************************************************************
	// range and boundary detection
	// ************************************************************
	logic ovf_det;
	logic unf_det;
	logic a_is_inf;
	logic b_is_inf;
	logic a_is_zero;
	logic b_is_zero;

	// guard bit read at the three stages of the exponent path
	always_comb begin
		ovf_det = exp_sum[FPM_EXT_MSB] & exp_unb[FPM_EXT_MSB] & exp_fin[FPM_EXT_MSB];
		unf_det = ~exp_sum[FPM_EXT_MSB] & exp_fin[FPM_EXT_MSB];
	end

	// infinity reserves the top exponent code with a zero fraction
	always_comb begin
		a_is_inf  = (op_a.frac == FPM_FRAC_ZERO) && (op_a.exp == FPM_EXP_TOP);
		b_is_inf  = (op_b.frac == FPM_FRAC_ZERO) && (op_b.exp == FPM_EXP_TOP);
		a_is_zero = (op_a.frac == FPM_FRAC_ZERO) && !a_is_inf;
		b_is_zero = (op_b.frac == FPM_FRAC_ZERO) && !b_is_inf;
	end

	// ************************************************************
	// result selection
	// ************************************************************
	// baseline passes the raw result with every flag low
	always_comb begin
		res   = raw;
		flags = '0;
		if (CHECK_EN) begin
			if ((a_is_inf && b_is_zero) || (b_is_inf && a_is_zero)) begin
				// zero times infinity has no value
				flags.nan = 1'b1;
				res.frac  = FPM_PROD_NAN;
				res.exp   = FPM_NAN_EXP;
			end else if (a_is_inf || b_is_inf || ovf_det) begin
				// infinite operand or too large for the field, pinned at infinity
				flags.overflow = ovf_det && !(a_is_inf || b_is_inf);
				flags.infinity = 1'b1;
				res.frac       = FPM_PROD_ZERO;
				res.exp        = FPM_EXP_TOP;
			end else if (unf_det) begin
				// too small for the field, flushed to zero
				flags.underflow = 1'b1;
				res.frac        = FPM_PROD_ZERO;
				res.exp         = FPM_EXP_ZERO;
			end
		end
	end

	// ************************************************************
	// outputs, no storage anywhere in the path
	// ************************************************************
	assign o_sign_out  = res.sign;
	assign o_frac_out  = res.frac;
	assign o_exp_out   = res.exp;
	assign o_overflow  = flags.overflow;
	assign o_underflow = flags.underflow;
	assign o_infinity  = flags.infinity;
	assign o_nan       = flags.nan;

	// ************************************************************
	// checks on the settled combinational values
	// ************************************************************
	// reference product and exponent rebuilt from the inputs, reusing the datapath norm_shift and frac_norm
	logic [FPM_PROD_BITS-1:0] chk_prod;
	logic [FPM_EXT_BITS-1:0]  chk_exp;
	logic                     chk_top;

	always_comb begin
		chk_prod = FPM_PROD_BITS'(i_frac_in_a) * FPM_PROD_BITS'(i_frac_in_b);
		chk_exp  = FPM_EXT_BITS'(i_exp_in_a) + FPM_EXT_BITS'(i_exp_in_b)
			- FPM_EXP_BIAS - FPM_EXT_BITS'(norm_shift);
		chk_top  = frac_norm[FPM_PROD_BITS-1];
	end

	always_comb begin
		AST_SIGN_XNOR: assert final (res.sign == (i_sign_in_a ~^ i_sign_in_b))
			else $error("output sign is not the xnor of the input signs");
		AST_NORM_TOP: assert final ((frac_prod == FPM_PROD_ZERO) || chk_top)
			else $error("normalized nonzero product lacks a top one bit");
		AST_NORM_VALUE: assert final ((chk_prod << norm_shift) == frac_norm)
			else $error("normalized fraction is not the shifted product");
		AST_ZERO_STOP: assert final ((frac_prod != FPM_PROD_ZERO)
			|| (32'(norm_shift) == FPM_PROD_BITS))
			else $error("zero product shift is not the full width");
		AST_SHIFT_MIN: assert final ((frac_prod == FPM_PROD_ZERO)
			|| (frac_prod[FPM_PROD_BITS-1 -: 1] == 1'b1) || (norm_shift != '0))
			else $error("product without top one was not shifted");
		AST_EXP_PATH: assert final (exp_fin == chk_exp)
			else $error("exponent is not sum minus bias minus shift");
		AST_BASE_RAW: assert final (CHECK_EN || (res == raw))
			else $error("baseline result differs from the raw result");
		AST_BASE_FLAGS: assert final (CHECK_EN
			|| !(o_overflow || o_underflow || o_infinity || o_nan))
			else $error("baseline raised a range or boundary flag");
		AST_INF_CODE: assert final (!o_infinity
			|| ((o_frac_out == FPM_PROD_ZERO) && (o_exp_out == FPM_EXP_TOP)))
			else $error("infinity flag without the infinity encoding");
		AST_NAN_CODE: assert final (!o_nan
			|| ((o_frac_out == FPM_PROD_NAN) && (o_exp_out != FPM_EXP_ZERO)))
			else $error("nan flag without the nan encoding");
		AST_FLAG_EXCL: assert final (!(o_overflow && o_underflow))
			else $error("overflow and underflow raised together");
	end

	// sampled checks; inputs move on the falling edge, so all is settled here
	AST_P_SIGN: assert property (@(posedge i_clk_sys) o_sign_out == (i_sign_in_a ~^ i_sign_in_b))
		else $error("sampled sign is not the xnor of the input signs");
	AST_P_PROD: assert property (@(posedge i_clk_sys) frac_prod == chk_prod)
		else $error("sampled product differs from the unsigned product");
	AST_P_NORM_TOP: assert property (@(posedge i_clk_sys)
		(frac_prod == FPM_PROD_ZERO) || frac_norm[FPM_PROD_BITS-1])
		else $error("sampled nonzero product not normalized");
	AST_P_ZERO_STOP: assert property (@(posedge i_clk_sys)
		(frac_prod != FPM_PROD_ZERO) || (norm_shift == FPM_SHF_BITS'(FPM_PROD_BITS)))
		else $error("sampled zero product shift is not the full width");
	AST_P_EXP: assert property (@(posedge i_clk_sys) exp_fin == chk_exp)
		else $error("sampled exponent is not sum minus bias minus shift");
	AST_P_BASE_FLAGS: assert property (@(posedge i_clk_sys)
		CHECK_EN || !(o_overflow || o_underflow || o_infinity || o_nan))
		else $error("sampled baseline flag raised");
	AST_P_NAN_CODE: assert property (@(posedge i_clk_sys)
		!o_nan || ((o_frac_out == FPM_PROD_NAN) && (o_exp_out != FPM_EXP_ZERO)))
		else $error("sampled nan flag without the nan encoding");

endmodule

`default_nettype wire

// ===== verification/fpm_operand_src.sv
// operand source standing in for the user logic that feeds the multiplier
`timescale 1ns/10ps
`default_nettype none

module fpm_operand_src
	import fpm_pkg::*;
(
	// clock and reset
	input  wire logic i_clk_sys,
	input  wire logic i_rst,
	// operand pair towards the multiplier
	output var  fpm_operand_t o_op_a,
	output var  fpm_operand_t o_op_b
);
	// ************************************************************
	// operand drive
	// ************************************************************
	// quiet zero operands until the first request
	initial begin
		o_op_a = '0;
		o_op_b = '0;
	end

	// new operands land on a falling edge, never while reset is up
	task automatic apply(input fpm_operand_t a, input fpm_operand_t b);
		@(negedge i_clk_sys);
		while (i_rst) @(negedge i_clk_sys);
		o_op_a = a;
		o_op_b = b;
	endtask
endmodule

`default_nettype wire

// ===== verification/tb.sv
// self-checking bench for the floating-point multiplier, baseline and checked builds
`timescale 1ns/10ps
`default_nettype none

module tb
	import fpm_pkg::*;
;
	// ************************************************************
	// clock, reset, counters
	// ************************************************************
	logic         i_clk_sys;
	logic         i_rst;
	int           fail_count = 0;
	int           n_tests    = 0;
	int           cyc        = 0;
	fpm_operand_t op_a;
	fpm_operand_t op_b;
	wire logic [27:0] got0;
	wire logic [27:0] got1;

	// 200 MHz clock and a 10-cycle reset
	initial begin
		i_clk_sys = 1'b0;
		forever #2.5 i_clk_sys = ~i_clk_sys;
	end
	initial begin
		i_rst = 1'b1;
		repeat (10) @(posedge i_clk_sys);
		@(negedge i_clk_sys) i_rst = 1'b0;
	end

	// ************************************************************
	// operand source and the two builds
	// ************************************************************
	fpm_operand_src src (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .o_op_a(op_a), .o_op_b(op_b));

	fpm_float_multiplier #(.CHECK_EN(1'b0)) dut (
		.i_clk_sys(i_clk_sys),
		.i_sign_in_a(op_a.sign), .i_frac_in_a(op_a.frac), .i_exp_in_a(op_a.exp),
		.i_sign_in_b(op_b.sign), .i_frac_in_b(op_b.frac), .i_exp_in_b(op_b.exp),
		.o_sign_out(got0[27]), .o_frac_out(got0[26:11]), .o_exp_out(got0[10:4]),
		.o_overflow(got0[3]), .o_underflow(got0[2]), .o_infinity(got0[1]), .o_nan(got0[0]));

	fpm_float_multiplier #(.CHECK_EN(1'b1)) dut_chk (
		.i_clk_sys(i_clk_sys),
		.i_sign_in_a(op_a.sign), .i_frac_in_a(op_a.frac), .i_exp_in_a(op_a.exp),
		.i_sign_in_b(op_b.sign), .i_frac_in_b(op_b.frac), .i_exp_in_b(op_b.exp),
		.o_sign_out(got1[27]), .o_frac_out(got1[26:11]), .o_exp_out(got1[10:4]),
		.o_overflow(got1[3]), .o_underflow(got1[2]), .o_infinity(got1[1]), .o_nan(got1[0]));

	// ************************************************************
	// reference model and checking helpers
	// ************************************************************
	// packed {sign, frac, exp, overflow, underflow, infinity, nan}
	function automatic logic [27:0] model(fpm_operand_t a, fpm_operand_t b, bit chk);
		logic [15:0] p;
		logic [15:0] f;
		logic [7:0]  sum;
		logic [7:0]  unb;
		logic [7:0]  fin;
		logic        sg;
		logic        ia;
		logic        ib;
		logic        ovf;
		int          s;
		p = a.frac * b.frac;
		s = 0;
		while (s < 16 && p[15-s] == 1'b0) s++;
		f = (s == 16) ? 16'h0000 : p << s;
		sum = {1'b0, a.exp} + {1'b0, b.exp};
		unb = sum - 8'h40;
		fin = unb - 8'(s);
		sg = ~(a.sign ^ b.sign);
		ia = (a.frac == 8'h00) && (a.exp == 7'h7F);
		ib = (b.frac == 8'h00) && (b.exp == 7'h7F);
		ovf = sum[7] & unb[7] & fin[7];
		if (!chk) return {sg, f, fin[6:0], 4'h0};
		if ((ia && b.frac == 8'h00 && !ib) || (ib && a.frac == 8'h00 && !ia))
			return {sg, 16'h8000, 7'h40, 4'h1};
		if (ia || ib || ovf) return {sg, 16'h0000, 7'h7F, ovf & ~ia & ~ib, 3'h2};
		if (~sum[7] & fin[7]) return {sg, 16'h0000, 7'h00, 4'h4};
		return {sg, f, fin[6:0], 4'h0};
	endfunction

	// one comparison, reported at once on mismatch
	task automatic cmp(input logic [27:0] got, input logic [27:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// apply a pair, let it settle, judge both builds
	task automatic check(input fpm_operand_t a, input fpm_operand_t b);
		src.apply(a, b);
		#1;
		cmp(got0, model(a, b, 1'b0));
		cmp(got1, model(a, b, 1'b1));
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	// worked product, checked against hand figures too
	task automatic sc_walk();
		check('{1'b1, 8'h9C, 7'h50}, '{1'b1, 8'hCB, 7'h4E});
		cmp(got0, {1'b1, 16'hF768, 7'h5D, 4'h0});
	endtask

	// every pair of input signs
	task automatic sc_signs();
		for (int i = 0; i < 4; i++) begin
			check('{i[1], 8'hC0, 7'h41}, '{i[0], 8'hA0, 7'h3F});
			cmp({27'h0, got0[27]}, {27'h0, ~(i[1] ^ i[0])});
		end
	endtask

	// shift of none, fifteen and a zero product
	task automatic sc_norm();
		check('{1'b1, 8'hFF, 7'h40}, '{1'b1, 8'hFF, 7'h40});
		check('{1'b1, 8'h01, 7'h50}, '{1'b0, 8'h01, 7'h50});
		check('{1'b0, 8'h00, 7'h45}, '{1'b1, 8'hA1, 7'h45});
		check('{1'b1, 8'h80, 7'h40}, '{1'b1, 8'h80, 7'h40});
	endtask

	// exponent code extremes, wrap in the baseline build
	task automatic sc_range();
		check('{1'b1, 8'hFF, 7'h7F}, '{1'b1, 8'hFF, 7'h7F});
		check('{1'b1, 8'h01, 7'h00}, '{1'b1, 8'h01, 7'h00});
		check('{1'b1, 8'h80, 7'h20}, '{1'b1, 8'h80, 7'h20});
		check('{1'b1, 8'hCE, 7'h4A}, '{1'b0, 8'h0C, 7'h36});
		check('{1'b1, 8'hC0, 7'h7F}, '{1'b1, 8'h80, 7'h41});
		check('{1'b0, 8'h80, 7'h00}, '{1'b1, 8'hC0, 7'h40});
	endtask

	// infinity operand and zero times infinity
	task automatic sc_bound();
		check('{1'b1, 8'h00, 7'h7F}, '{1'b0, 8'h80, 7'h40});
		check('{1'b1, 8'h00, 7'h7F}, '{1'b1, 8'h00, 7'h40});
		check('{1'b0, 8'h00, 7'h33}, '{1'b1, 8'h00, 7'h7F});
		check('{1'b1, 8'h00, 7'h7F}, '{1'b1, 8'h00, 7'h7F});
	endtask

	// ************************************************************
	// run control
	// ************************************************************
	task automatic give_verdict();
		$display("checks=%0d mismatches=%0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// cycle ceiling against a hang
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			fail_count++;
			give_verdict();
		end
	end

	initial begin
		sc_walk();
		sc_signs();
		sc_norm();
		sc_range();
		sc_bound();
		give_verdict();
	end
endmodule

`default_nettype wire
